/* design/gnd_prot_pkg.sv */
package gnd_prot_pkg;

	// ==========================================================
	// clock and tick timebase
	localparam int CLK_FREQ_HZ = 125_000_000;
	localparam int TICK_TIME_MS = 10;
	localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
	// internal timeout step is 0.1 s, external step is 0.01 s
	localparam int INT_STEP_MS = 100;
	localparam int EXT_STEP_MS = 10;
	localparam logic [15:0] INT_STEP_TICKS = 16'(INT_STEP_MS / TICK_TIME_MS);
	localparam logic [15:0] EXT_STEP_TICKS = 16'(EXT_STEP_MS / TICK_TIME_MS);

	// ==========================================================
	// register offsets (byte addresses, one word each)
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLC_MIN = 8'h04;
	localparam logic [7:0] OFS_INT_TIMEOUT = 8'h08;
	localparam logic [7:0] OFS_INT_FAULT_PCT = 8'h0c;
	localparam logic [7:0] OFS_INT_WARN_PCT = 8'h10;
	localparam logic [7:0] OFS_EXT_TIMEOUT = 8'h14;
	localparam logic [7:0] OFS_EXT_FAULT_LVL = 8'h18;
	localparam logic [7:0] OFS_EXT_WARN_LVL = 8'h1c;
	localparam logic [7:0] OFS_EXT_RATIO = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_GND_CURRENT = 8'h28;
	localparam logic [7:0] OFS_GND_RATIO = 8'h2c;
	localparam logic [7:0] OFS_FAULT_COUNT = 8'h30;

	// ==========================================================
	// control field positions
	localparam int CTRL_MODE_EXT = 0;
	localparam int CTRL_FAULT_EN = 1;
	localparam int CTRL_WARN_EN = 2;
	localparam int CTRL_START_SUPP = 3;

	// ==========================================================
	// factory values
	localparam logic [3:0] CTRL_RESET = 4'he;
	localparam logic [15:0] FLC_MIN_RESET = 16'h0064;
	localparam logic [15:0] INT_TIMEOUT_RESET = 16'h000a;
	localparam logic [15:0] INT_PCT_RESET = 16'h0032;
	localparam logic [15:0] EXT_TIMEOUT_RESET = 16'h0032;
	localparam logic [15:0] EXT_LVL_RESET = 16'h0064;
	localparam logic [15:0] EXT_RATIO_RESET = 16'h0000;

	// ==========================================================
	// hysteresis: clear below 95 % of threshold, as 19/20
	localparam logic [39:0] HYST_NUM = 40'h13;
	localparam logic [39:0] HYST_DEN = 40'h14;
	localparam logic [31:0] PCT_SCALE = 32'h64;

	// ==========================================================
	// motor states
	typedef enum logic [1:0] {
		MOTOR_OFF = 2'b00,
		MOTOR_READY = 2'b01,
		MOTOR_START = 2'b10,
		MOTOR_RUN = 2'b11
	} motor_state_t;

endpackage

/* design/ratio_divider.sv */
`timescale 1ns/100ps

// restoring divider, one quotient bit per cycle
module ratio_divider (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request
	input wire logic start,
	input wire logic [31:0] dividend,
	input wire logic [15:0] divisor,
	// answer
	output logic [15:0] quotient,
	output logic done
);

	typedef struct packed {
		logic busy_r;
		logic [5:0] cnt_r;
		logic [16:0] rem_r;
		logic [31:0] quo_r;
		logic [15:0] div_r;
		logic [15:0] result_r;
		logic done_r;
	} div_state_t;

	div_state_t st_r;
	div_state_t st_nxt;

	always_comb begin
		logic [16:0] rem_sh;
		rem_sh = {st_r.rem_r[15:0], st_r.quo_r[31]};
		st_nxt = st_r;
		st_nxt.done_r = 1'b0;
		if (!st_r.busy_r) begin
			// a start while busy is ignored; the caller retries next tick
			if (start) begin
				st_nxt.busy_r = 1'b1;
				st_nxt.cnt_r = 6'h00;
				st_nxt.rem_r = 17'h00000;
				st_nxt.quo_r = dividend;
				st_nxt.div_r = divisor;
			end
		end else begin
			st_nxt.quo_r = {st_r.quo_r[30:0], 1'b0};
			st_nxt.rem_r = rem_sh;
			if (rem_sh >= {1'b0, st_r.div_r}) begin
				st_nxt.rem_r = rem_sh - {1'b0, st_r.div_r};
				st_nxt.quo_r[0] = 1'b1;
			end
			st_nxt.cnt_r = st_r.cnt_r + 6'h01;
			if (st_r.cnt_r == 6'h1f) begin
				st_nxt.busy_r = 1'b0;
				st_nxt.done_r = 1'b1;
				// saturate: zero divisor or oversize quotient reads all ones
				if (st_r.div_r == 16'h0000 || st_nxt.quo_r[31:16] != 16'h0000) begin
					st_nxt.result_r = 16'hffff;
				end else begin
					st_nxt.result_r = st_nxt.quo_r[15:0];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign quotient = st_r.result_r;
	assign done = st_r.done_r;

endmodule // ratio_divider

/* design/ground_current_protection.sv */
`timescale 1ns/100ps

// What this block does
// - summed-phase detection runs only when the source selection is internal.
// - only one source, internal or external, is ever active.
// - control holds source, fault, warning, suppress; factory: internal, all enabled.
// - internal warning asserts while three-phase sum exceeds warning threshold.
// - internal fault asserts after sum stays above fault threshold for timeout.
// - internal detection in ready, start, run; suppress option removes start state.
// - warning and fault detection have independent enables.
// - internal timeout counts in 0.1 s steps, factory 1 s.
// - internal thresholds in 1 % of minimum full load current, factory 50 %.
// - ground current also reported as percent of minimum full load current.
// - each condition clears only below 95 % of its threshold.
// - external detection runs only when external selected and ratio configured.
// - with internal selected, external outputs stay deasserted.
// - external warning asserts while transformer current exceeds warning level.
// - external fault asserts after current stays above fault level for timeout.
// - external detection in ready, start, run; suppress option removes start state.
// - external timeout counts in 0.01 s steps, factory 0.5 s.
// - external levels in 0.01 A steps, factory 1 A.
// - one shared counter of ground faults from either source.
// - internal and external detection have separate warning and fault outputs.
module ground_current_protection #(
	parameter int TICK_CYCLES = gnd_prot_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// measurements, 0.01 A units
	input wire logic [15:0] phase1_current,
	input wire logic [15:0] phase2_current,
	input wire logic [15:0] phase3_current,
	input wire logic [15:0] ext_transformer_current,
	// motor state
	input wire logic [1:0] motor_state,
	// protection outputs
	output logic int_warning,
	output logic int_fault,
	output logic ext_warning,
	output logic ext_fault
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [3:0] ctrl_r;
		logic [15:0] flc_r;
		logic [15:0] int_to_r;
		logic [15:0] int_fpct_r;
		logic [15:0] int_wpct_r;
		logic [15:0] ext_to_r;
		logic [15:0] ext_flvl_r;
		logic [15:0] ext_wlvl_r;
		logic [15:0] ext_ratio_r;
		logic [20:0] tick_cnt_r;
		logic tick_r;
		logic int_warn_r;
		logic int_cond_r;
		logic int_fault_r;
		logic [15:0] int_tmr_r;
		logic ext_warn_r;
		logic ext_cond_r;
		logic ext_fault_r;
		logic [15:0] ext_tmr_r;
		logic [31:0] ground_r;
		logic [15:0] ratio_r;
		logic [15:0] fault_cnt_r;
		logic [31:0] rdata_r;
	} gp_state_t;

	gp_state_t st_r;
	gp_state_t st_nxt;

	// ==========================================================
	// helpers
	// set above threshold, clear only once below 95 % of it
	function automatic logic over_hyst(input logic prev, input logic [31:0] val, input logic [31:0] thr);
		logic [39:0] v20;
		logic [39:0] t19;
		v20 = {8'h00, val} * gnd_prot_pkg::HYST_DEN;
		t19 = {8'h00, thr} * gnd_prot_pkg::HYST_NUM;
		if (prev) begin
			over_hyst = (v20 >= t19);
		end else begin
			over_hyst = (val > thr);
		end
	endfunction

	function automatic logic motor_active(input logic [1:0] ms, input logic supp);
		case (gnd_prot_pkg::motor_state_t'(ms))
			gnd_prot_pkg::MOTOR_READY: motor_active = 1'b1;
			gnd_prot_pkg::MOTOR_START: motor_active = !supp;
			gnd_prot_pkg::MOTOR_RUN: motor_active = 1'b1;
			default: motor_active = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// measurement scaling
	logic [17:0] phase_sum;
	logic [31:0] int_val;
	logic [31:0] int_fthr;
	logic [31:0] int_wthr;
	logic [31:0] ext_val;
	logic [31:0] int_to_ticks;
	logic [31:0] ext_to_ticks;
	logic mode_ext;
	logic int_act;
	logic ext_act;
	logic [31:0] div_dividend;
	logic [15:0] div_quot;
	logic div_done;

	assign phase_sum = {2'b00, phase1_current} + {2'b00, phase2_current} + {2'b00, phase3_current};
	// internal compare is done in (0.01 A x %) so percent thresholds need no division
	assign int_val = {14'h0000, phase_sum} * gnd_prot_pkg::PCT_SCALE;
	assign int_fthr = {16'h0000, st_r.int_fpct_r} * {16'h0000, st_r.flc_r};
	assign int_wthr = {16'h0000, st_r.int_wpct_r} * {16'h0000, st_r.flc_r};
	assign ext_val = {16'h0000, ext_transformer_current} * {16'h0000, st_r.ext_ratio_r};
	assign int_to_ticks = {16'h0000, st_r.int_to_r} * {16'h0000, gnd_prot_pkg::INT_STEP_TICKS};
	assign ext_to_ticks = {16'h0000, st_r.ext_to_r} * {16'h0000, gnd_prot_pkg::EXT_STEP_TICKS};

	assign mode_ext = st_r.ctrl_r[gnd_prot_pkg::CTRL_MODE_EXT];
	// one mode bit selects exactly one source
	assign int_act = !mode_ext && motor_active(motor_state, st_r.ctrl_r[gnd_prot_pkg::CTRL_START_SUPP]);
	assign ext_act = mode_ext && (st_r.ext_ratio_r != 16'h0000) &&
		motor_active(motor_state, st_r.ctrl_r[gnd_prot_pkg::CTRL_START_SUPP]);

	// ratio = ground x 100 / minimum full load current; oversize ground saturates
	assign div_dividend = (st_r.ground_r[31:25] != 7'h00) ? 32'hffffffff :
		{7'h00, st_r.ground_r[24:0]} * gnd_prot_pkg::PCT_SCALE;

	ratio_divider u_div (
		.clk(clk),
		.rst(rst),
		.start(st_r.tick_r),
		.dividend(div_dividend),
		.divisor(st_r.flc_r),
		.quotient(div_quot),
		.done(div_done)
	);

	// ==========================================================
	// next state
	always_comb begin
		logic int_rise;
		logic ext_rise;
		int_rise = 1'b0;
		ext_rise = 1'b0;
		st_nxt = st_r;

		// fixed timebase tick
		st_nxt.tick_r = 1'b0;
		if (st_r.tick_cnt_r == 21'(TICK_CYCLES - 1)) begin
			st_nxt.tick_cnt_r = 21'h000000;
			st_nxt.tick_r = 1'b1;
		end else begin
			st_nxt.tick_cnt_r = st_r.tick_cnt_r + 21'h000001;
		end

		// internal detection
		st_nxt.int_warn_r = int_act && st_r.ctrl_r[gnd_prot_pkg::CTRL_WARN_EN] &&
			over_hyst(st_r.int_warn_r, int_val, int_wthr);
		st_nxt.int_cond_r = int_act && st_r.ctrl_r[gnd_prot_pkg::CTRL_FAULT_EN] &&
			over_hyst(st_r.int_cond_r, int_val, int_fthr);
		if (!st_nxt.int_cond_r) begin
			st_nxt.int_tmr_r = 16'h0000;
		end else if (st_r.tick_r && {16'h0000, st_r.int_tmr_r} < int_to_ticks) begin
			st_nxt.int_tmr_r = st_r.int_tmr_r + 16'h0001;
		end
		st_nxt.int_fault_r = st_nxt.int_cond_r && ({16'h0000, st_r.int_tmr_r} >= int_to_ticks);

		// external detection
		st_nxt.ext_warn_r = ext_act && st_r.ctrl_r[gnd_prot_pkg::CTRL_WARN_EN] &&
			over_hyst(st_r.ext_warn_r, ext_val, {16'h0000, st_r.ext_wlvl_r});
		st_nxt.ext_cond_r = ext_act && st_r.ctrl_r[gnd_prot_pkg::CTRL_FAULT_EN] &&
			over_hyst(st_r.ext_cond_r, ext_val, {16'h0000, st_r.ext_flvl_r});
		if (!st_nxt.ext_cond_r) begin
			st_nxt.ext_tmr_r = 16'h0000;
		end else if (st_r.tick_r && {16'h0000, st_r.ext_tmr_r} < ext_to_ticks) begin
			st_nxt.ext_tmr_r = st_r.ext_tmr_r + 16'h0001;
		end
		st_nxt.ext_fault_r = st_nxt.ext_cond_r && ({16'h0000, st_r.ext_tmr_r} >= ext_to_ticks);

		// shared fault statistic, saturating
		int_rise = st_nxt.int_fault_r && !st_r.int_fault_r;
		ext_rise = st_nxt.ext_fault_r && !st_r.ext_fault_r;
		if ((int_rise || ext_rise) && st_r.fault_cnt_r != 16'hffff) begin
			st_nxt.fault_cnt_r = st_r.fault_cnt_r + 16'h0001;
		end

		// measurements reported
		st_nxt.ground_r = mode_ext ? ext_val : {14'h0000, phase_sum};
		if (div_done) begin
			st_nxt.ratio_r = div_quot;
		end

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				gnd_prot_pkg::OFS_CTRL: st_nxt.ctrl_r = reg_wdata[3:0];
				gnd_prot_pkg::OFS_FLC_MIN: st_nxt.flc_r = reg_wdata[15:0];
				gnd_prot_pkg::OFS_INT_TIMEOUT: st_nxt.int_to_r = reg_wdata[15:0];
				gnd_prot_pkg::OFS_INT_FAULT_PCT: st_nxt.int_fpct_r = reg_wdata[15:0];
				gnd_prot_pkg::OFS_INT_WARN_PCT: st_nxt.int_wpct_r = reg_wdata[15:0];
				gnd_prot_pkg::OFS_EXT_TIMEOUT: st_nxt.ext_to_r = reg_wdata[15:0];
				gnd_prot_pkg::OFS_EXT_FAULT_LVL: st_nxt.ext_flvl_r = reg_wdata[15:0];
				gnd_prot_pkg::OFS_EXT_WARN_LVL: st_nxt.ext_wlvl_r = reg_wdata[15:0];
				gnd_prot_pkg::OFS_EXT_RATIO: st_nxt.ext_ratio_r = reg_wdata[15:0];
				default: begin
				end
			endcase
		end

		// register reads: data stands one cycle only, unmapped reads zero
		st_nxt.rdata_r = 32'h00000000;
		if (reg_rd) begin
			case (reg_addr)
				gnd_prot_pkg::OFS_CTRL: st_nxt.rdata_r = {28'h0000000, st_r.ctrl_r};
				gnd_prot_pkg::OFS_FLC_MIN: st_nxt.rdata_r = {16'h0000, st_r.flc_r};
				gnd_prot_pkg::OFS_INT_TIMEOUT: st_nxt.rdata_r = {16'h0000, st_r.int_to_r};
				gnd_prot_pkg::OFS_INT_FAULT_PCT: st_nxt.rdata_r = {16'h0000, st_r.int_fpct_r};
				gnd_prot_pkg::OFS_INT_WARN_PCT: st_nxt.rdata_r = {16'h0000, st_r.int_wpct_r};
				gnd_prot_pkg::OFS_EXT_TIMEOUT: st_nxt.rdata_r = {16'h0000, st_r.ext_to_r};
				gnd_prot_pkg::OFS_EXT_FAULT_LVL: st_nxt.rdata_r = {16'h0000, st_r.ext_flvl_r};
				gnd_prot_pkg::OFS_EXT_WARN_LVL: st_nxt.rdata_r = {16'h0000, st_r.ext_wlvl_r};
				gnd_prot_pkg::OFS_EXT_RATIO: st_nxt.rdata_r = {16'h0000, st_r.ext_ratio_r};
				gnd_prot_pkg::OFS_STATUS: st_nxt.rdata_r = {26'h0000000, ext_act, int_act,
					st_r.ext_fault_r, st_r.ext_warn_r, st_r.int_fault_r, st_r.int_warn_r};
				gnd_prot_pkg::OFS_GND_CURRENT: st_nxt.rdata_r = st_r.ground_r;
				gnd_prot_pkg::OFS_GND_RATIO: st_nxt.rdata_r = {16'h0000, st_r.ratio_r};
				gnd_prot_pkg::OFS_FAULT_COUNT: st_nxt.rdata_r = {16'h0000, st_r.fault_cnt_r};
				default: st_nxt.rdata_r = 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.ctrl_r <= gnd_prot_pkg::CTRL_RESET;
			st_r.flc_r <= gnd_prot_pkg::FLC_MIN_RESET;
			st_r.int_to_r <= gnd_prot_pkg::INT_TIMEOUT_RESET;
			st_r.int_fpct_r <= gnd_prot_pkg::INT_PCT_RESET;
			st_r.int_wpct_r <= gnd_prot_pkg::INT_PCT_RESET;
			st_r.ext_to_r <= gnd_prot_pkg::EXT_TIMEOUT_RESET;
			st_r.ext_flvl_r <= gnd_prot_pkg::EXT_LVL_RESET;
			st_r.ext_wlvl_r <= gnd_prot_pkg::EXT_LVL_RESET;
			st_r.ext_ratio_r <= gnd_prot_pkg::EXT_RATIO_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// separate flags per source
	assign int_warning = st_r.int_warn_r;
	assign int_fault = st_r.int_fault_r;
	assign ext_warning = st_r.ext_warn_r;
	assign ext_fault = st_r.ext_fault_r;
	assign reg_rdata = st_r.rdata_r;

	// ==========================================================
	// assertions
	sequence s_int_cond_drop;
		st_r.int_cond_r ##1 !st_r.int_cond_r;
	endsequence

	sequence s_any_fault_rise;
		$rose(st_r.int_fault_r) || $rose(st_r.ext_fault_r);
	endsequence

	a_int_off_ext: assert property (@(posedge clk) disable iff (rst)
		mode_ext |=> !int_warning && !int_fault)
		else $error("internal output active in external mode");

	a_ext_off_int: assert property (@(posedge clk) disable iff (rst)
		!mode_ext |=> !ext_warning && !ext_fault)
		else $error("external output active in internal mode");

	a_one_source: assert property (@(posedge clk) disable iff (rst)
		!((int_warning || int_fault) && (ext_warning || ext_fault)))
		else $error("both sources active");

	a_ratio_gate: assert property (@(posedge clk) disable iff (rst)
		(st_r.ext_ratio_r == 16'h0000) |=> !ext_warning && !ext_fault)
		else $error("external detection without ratio");

	a_reset_cfg: assert property (@(posedge clk)
		rst |=> st_r.ctrl_r == gnd_prot_pkg::CTRL_RESET && st_r.int_to_r == gnd_prot_pkg::INT_TIMEOUT_RESET)
		else $error("factory configuration wrong");

	a_warn_gate: assert property (@(posedge clk) disable iff (rst)
		!st_r.ctrl_r[gnd_prot_pkg::CTRL_WARN_EN] |=> !int_warning && !ext_warning)
		else $error("warning while disabled");

	a_start_supp: assert property (@(posedge clk) disable iff (rst)
		(motor_state == 2'h2 && st_r.ctrl_r[gnd_prot_pkg::CTRL_START_SUPP])
		|=> !int_warning && !int_fault && !ext_warning && !ext_fault)
		else $error("detection active in suppressed start");

	a_int_warn_set: assert property (@(posedge clk) disable iff (rst)
		(int_act && st_r.ctrl_r[gnd_prot_pkg::CTRL_WARN_EN] && int_val > int_wthr) |=> int_warning)
		else $error("internal warning missed");

	a_int_fault_time: assert property (@(posedge clk) disable iff (rst)
		$rose(st_r.int_fault_r) |-> st_r.int_cond_r && ({16'h0000, $past(st_r.int_tmr_r)} >= $past(int_to_ticks)))
		else $error("internal fault before timeout");

	a_ext_fault_time: assert property (@(posedge clk) disable iff (rst)
		$rose(st_r.ext_fault_r) |-> st_r.ext_cond_r && ({16'h0000, $past(st_r.ext_tmr_r)} >= $past(ext_to_ticks)))
		else $error("external fault before timeout");

	a_timer_restart: assert property (@(posedge clk) disable iff (rst)
		s_int_cond_drop |-> st_r.int_tmr_r == 16'h0000)
		else $error("fault timer not restarted");

	a_fault_count: assert property (@(posedge clk) disable iff (rst)
		(s_any_fault_rise ##0 ($past(st_r.fault_cnt_r) != 16'hffff))
		|-> st_r.fault_cnt_r == $past(st_r.fault_cnt_r) + 16'h0001)
		else $error("fault count not advanced");

	// a warning that drops while still enabled and active must be below the 95 % band
	a_warn_hyst: assert property (@(posedge clk) disable iff (rst)
		($fell(int_warning) && $past(int_act) && $past(st_r.ctrl_r[gnd_prot_pkg::CTRL_WARN_EN]))
		|-> ({8'h00, $past(int_val)} * gnd_prot_pkg::HYST_DEN) < ({8'h00, $past(int_wthr)} * gnd_prot_pkg::HYST_NUM))
		else $error("internal warning cleared inside hysteresis band");

	a_fault_gate: assert property (@(posedge clk) disable iff (rst)
		!st_r.ctrl_r[gnd_prot_pkg::CTRL_FAULT_EN] |=> !int_fault && !ext_fault)
		else $error("fault while disabled");

	a_ext_warn_set: assert property (@(posedge clk) disable iff (rst)
		(ext_act && st_r.ctrl_r[gnd_prot_pkg::CTRL_WARN_EN] && ext_val > {16'h0000, st_r.ext_wlvl_r})
		|=> ext_warning)
		else $error("external warning missed");

	a_motor_off: assert property (@(posedge clk) disable iff (rst)
		(motor_state == gnd_prot_pkg::MOTOR_OFF)
		|=> !int_warning && !int_fault && !ext_warning && !ext_fault)
		else $error("detection active with motor off");

endmodule // ground_current_protection

/* sim/ct_source_model.sv */
`timescale 1ns/100ps

// ==========
// current transformer secondaries seen by the protection block
module ct_source_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// wanted readings and pace
	input wire logic [15:0] want1,
	input wire logic [15:0] want2,
	input wire logic [15:0] want3,
	input wire logic [15:0] want_ext,
	input wire logic slow,
	// secondaries
	output logic [15:0] phase1,
	output logic [15:0] phase2,
	output logic [15:0] phase3,
	output logic [15:0] ext_out
);
	logic [1:0] pace_r;

	// a slow transformer settles only every fourth cycle, like a filtered secondary
	always_ff @(posedge clk) begin
		if (rst) begin
			pace_r <= 2'h0;
			phase1 <= 16'h0000;
			phase2 <= 16'h0000;
			phase3 <= 16'h0000;
			ext_out <= 16'h0000;
		end else begin
			pace_r <= pace_r + 2'h1;
			if (!slow || pace_r == 2'h0) begin
				phase1 <= want1;
				phase2 <= want2;
				phase3 <= want3;
				ext_out <= want_ext;
			end
		end
	end
endmodule // ct_source_model

/* sim/test_ground_current_protection.sv */
`timescale 1ns/100ps

// ==========
// self-checking bench, internal and external ground detection
module test_ground_current_protection;
	logic clk, rst, reg_wr, reg_rd, slow, rd_pend, hi;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] w1, w2, w3, wext, p1, p2, p3, pext, s;
	logic [1:0] motor_state;
	logic int_warning, int_fault, ext_warning, ext_fault;
	logic [31:0] exp_q[$];
	int errors, n_compared, seed;
	logic [7:0] ofs[12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30, 8'h3c};
	logic [31:0] fac[12] = '{32'he, 32'h64, 32'ha, 32'h32, 32'h32, 32'h32, 32'h64, 32'h64, 32'h0, 32'h0, 32'h0, 32'h0};

	ct_source_model ct_source_model_inst (.clk(clk), .rst(rst), .want1(w1), .want2(w2), .want3(w3),
		.want_ext(wext), .slow(slow), .phase1(p1), .phase2(p2), .phase3(p3), .ext_out(pext));

	// tick shortened to 10 clocks so a 0.1 s step is 100 clocks
	ground_current_protection #(.TICK_CYCLES(10)) ground_current_protection_inst (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.phase1_current(p1), .phase2_current(p2), .phase3_current(p3), .ext_transformer_current(pext),
		.motor_state(motor_state), .int_warning(int_warning), .int_fault(int_fault),
		.ext_warning(ext_warning), .ext_fault(ext_fault));

	task automatic give_verdict();
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic pin(input int i);
		logic [3:0] v;
		v = {ext_fault, ext_warning, int_fault, int_warning};
		return v[i];
	endfunction

	// ==========
	// register port, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_pend) begin
			cmp_word(reg_rdata, exp_q.pop_front());
		end
		rd_pend = reg_rd;
	end

	// ==========
	// flag waits, always bounded
	task automatic wait_pin(input int i, input logic v, input int n);
		int k;
		k = 0;
		while (pin(i) !== v && k < n) begin
			@(posedge clk);
			k++;
		end
		cmp_bit(pin(i), v);
		if (pin(i) !== v) begin
			give_verdict();
		end
	endtask

	task automatic hold_pin(input int i, input logic v, input int n);
		repeat (n) begin
			@(posedge clk);
			cmp_bit(pin(i), v);
		end
	endtask

	// the sum is split in thirds, remainder on phase 3, so that only the total matters
	task automatic set_sum(input logic [15:0] t);
		w1 <= t / 16'h3;
		w2 <= t / 16'h3;
		w3 <= t - 16'h2 * (t / 16'h3);
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	initial begin
		errors = 0;
		n_compared = 0;
		seed = 93743;
		rd_pend = 1'b0;
		rst = 1'b1;
		{reg_wr, reg_rd, slow} = 3'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		{w1, w2, w3, wext} = 64'h0;
		motor_state = 2'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (ofs[i]) rd(ofs[i], fac[i]);
		wr(8'h24, 32'hffff);
		rd(8'h24, 32'h0);
		motor_state <= 2'h3;
		wr(8'h08, 32'h1);
		set_sum(16'h33);
		wait_pin(0, 1'b1, 4);
		set_sum(16'h30);
		hold_pin(0, 1'b1, 5);
		set_sum(16'h2f);
		wait_pin(0, 1'b0, 4);
		set_sum(16'h33);
		hold_pin(1, 1'b0, 70);
		set_sum(16'h28);
		repeat (3) @(posedge clk);
		set_sum(16'h33);
		hold_pin(1, 1'b0, 70);
		wait_pin(1, 1'b1, 60);
		rd(8'h30, 32'h1);
		rd(8'h24, 32'h13);
		set_sum(16'h0);
		wait_pin(1, 1'b0, 4);
		motor_state <= 2'h2;
		set_sum(16'h3c);
		hold_pin(0, 1'b0, 6);
		wr(8'h00, 32'h6);
		wait_pin(0, 1'b1, 4);
		motor_state <= 2'h0;
		wait_pin(0, 1'b0, 4);
		motor_state <= 2'h1;
		wait_pin(0, 1'b1, 4);
		motor_state <= 2'h3;
		wr(8'h00, 32'ha);
		hold_pin(0, 1'b0, 6);
		wr(8'h00, 32'h4);
		wait_pin(0, 1'b1, 4);
		hold_pin(1, 1'b0, 150);
		set_sum(16'h4b);
		// the ratio refreshes only on a free divider, up to about 75 clocks after the sum moves
		repeat (100) @(posedge clk);
		rd(8'h28, 32'h4b);
		rd(8'h2c, 32'h4b);
		wr(8'h00, 32'hf);
		wext <= 16'h65;
		hold_pin(2, 1'b0, 6);
		cmp_bit(int_warning, 1'b0);
		wr(8'h14, 32'h2);
		wr(8'h20, 32'h1);
		wait_pin(2, 1'b1, 4);
		hold_pin(3, 1'b0, 8);
		wait_pin(3, 1'b1, 30);
		cmp_bit(int_warning, 1'b0);
		rd(8'h30, 32'h2);
		motor_state <= 2'h2;
		wait_pin(3, 1'b0, 4);
		cmp_bit(ext_warning, 1'b0);
		motor_state <= 2'h3;
		wr(8'h00, 32'he);
		wait_pin(2, 1'b0, 4);
		hold_pin(3, 1'b0, 3);
		wr(8'h00, 32'h4);
		slow <= 1'b1;
		repeat (12) begin
			hi = 1'($random(seed));
			s = hi ? 16'(51 + $unsigned($random(seed)) % 200) : 16'($unsigned($random(seed)) % 48);
			set_sum(s);
			wext <= 16'($random(seed));
			wait_pin(0, hi, 10);
		end
		repeat (4) @(posedge clk);
		give_verdict();
	end
endmodule // test_ground_current_protection
